//--- oms_pkg.sv
// oms_pkg: constants and carrier types for the optical motion sensor register bank
// assumes: shared by oms_regs (link clock domain logic) and oms_serial (serial port engine)
package oms_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [6:0] OMS_ADDR_CFG1 = 7'h00;
  localparam logic [6:0] OMS_ADDR_STAT1 = 7'h01;
  localparam logic [6:0] OMS_ADDR_DY1 = 7'h02;
  localparam logic [6:0] OMS_ADDR_DX1 = 7'h03;
  localparam logic [6:0] OMS_ADDR_SQ1 = 7'h04;
  localparam logic [6:0] OMS_ADDR_MAXP1 = 7'h05;
  localparam logic [6:0] OMS_ADDR_MINP1 = 7'h06;
  localparam logic [6:0] OMS_ADDR_PSUM1 = 7'h07;
  localparam logic [6:0] OMS_ADDR_PDAT1 = 7'h08;
  localparam logic [6:0] OMS_ADDR_SHU1 = 7'h09;
  localparam logic [6:0] OMS_ADDR_SHL1 = 7'h0a;
  localparam logic [6:0] OMS_ADDR_GRAB = 7'h0b;
  localparam logic [6:0] OMS_ADDR_PIDA = 7'h14;
  localparam logic [6:0] OMS_ADDR_PIDB = 7'h15;
  localparam logic [6:0] OMS_ADDR_MOT2 = 7'h16;
  localparam logic [6:0] OMS_ADDR_DX2 = 7'h17;
  localparam logic [6:0] OMS_ADDR_DY2 = 7'h18;
  localparam logic [6:0] OMS_ADDR_SQ2 = 7'h19;
  localparam logic [6:0] OMS_ADDR_OPM2 = 7'h1a;
  localparam logic [6:0] OMS_ADDR_CFG2 = 7'h1b;
  localparam logic [6:0] OMS_ADDR_PCTL = 7'h33;
  localparam logic [6:0] OMS_ADDR_CFG3 = 7'h40;
  localparam logic [6:0] OMS_ADDR_STAT3 = 7'h41;
  localparam logic [6:0] OMS_ADDR_DY3 = 7'h42;
  localparam logic [6:0] OMS_ADDR_DX3 = 7'h43;
  localparam logic [6:0] OMS_ADDR_SQ3 = 7'h44;
  localparam logic [6:0] OMS_ADDR_MAXP3 = 7'h45;
  localparam logic [6:0] OMS_ADDR_MINP3 = 7'h46;
  localparam logic [6:0] OMS_ADDR_PSUM3 = 7'h47;
  localparam logic [6:0] OMS_ADDR_PDAT3 = 7'h48;
  localparam logic [6:0] OMS_ADDR_SHU3 = 7'h49;
  localparam logic [6:0] OMS_ADDR_SHL3 = 7'h4a;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int OMS_CFG_RESET_BIT = 7;
  localparam int OMS_CFG_SHUTDOWN_BIT = 6;
  localparam int OMS_CFG_WAKE_BIT = 0;
  localparam logic [7:0] OMS_CFG_KEEP_MASK = 8'h41;
  localparam logic [7:0] OMS_RST_CFG = 8'h00;
  localparam logic [7:0] OMS_RST_MINP = 8'h3f;
  localparam logic [7:0] OMS_RST_SHU = 8'h01;
  localparam logic [7:0] OMS_RST_OPM = 8'h04;
  localparam logic [7:0] OMS_RST_PCTL = 8'h07;
  localparam logic [7:0] OMS_RST_ZERO = 8'h00;
  localparam logic [7:0] OMS_SQ_MAX = 8'h80;
  // ****************************************
  // timing
  // ****************************************
  localparam int OMS_CLK_HZ = 25000000;
  localparam int OMS_SLEEP_S = 1;
  localparam int OMS_SLEEP_CYC = OMS_SLEEP_S * OMS_CLK_HZ;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } oms_req_t;
  typedef struct packed {
    logic [8:0] features;
    logic [6:0] brightest;
    logic [5:0] darkest;
    logic [7:0] pix_total;
    logic [15:0] exposure;
  } oms_frame_t;
endpackage

//--- oms_serial.sv
// oms_serial: two-wire serial port engine, runs on the serial clock from the controller
// assumes: serial clock only toggles during transactions; data sampled on rising edge
module oms_serial
  import oms_pkg::*;
(
  input wire logic sclk_in,
  input wire logic rst_in,
  input wire logic sdio_in,
  input wire logic [7:0] rdata_in,
  output logic sdio_out,
  output logic sdio_oe_out,
  output oms_req_t req_out,
  output logic req_tgl_out
);
  // ****************************************
  // shift engine
  // ****************************************
  logic [4:0] bitcnt;
  logic [6:0] shift;
  logic wr_op;
  logic [7:0] rd_shift;
  logic [7:0] wr_shift;
  logic rd_phase;

  always_ff @(posedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      bitcnt <= 5'h00;
      shift <= 7'h00;
      wr_op <= 1'b0;
      wr_shift <= 8'h00;
      req_out <= '0;
      req_tgl_out <= 1'b0;
    end else begin
      bitcnt <= (bitcnt == 5'h0f) ? 5'h00 : bitcnt + 5'h01;
      if (bitcnt == 5'h00) begin
        wr_op <= sdio_in;
      end else if (bitcnt < 5'h08) begin
        shift <= {shift[5:0], sdio_in};
      end else begin
        wr_shift <= {wr_shift[6:0], sdio_in};
      end
      // address complete: post the request, reads are served before data bits
      if (bitcnt == 5'h07 && !wr_op) begin
        req_out <= '{wr: 1'b0, addr: {shift[5:0], sdio_in}, data: 8'h00};
        req_tgl_out <= ~req_tgl_out;
      end
      if (bitcnt == 5'h0f && wr_op) begin
        req_out <= '{wr: 1'b1, addr: shift, data: {wr_shift[6:0], sdio_in}};
        req_tgl_out <= ~req_tgl_out;
      end
    end
  end

  // read data shifts out on falling edges, msb first; held after the last bit until the first falling edge of the next frame
  always_ff @(negedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_phase <= 1'b0;
      rd_shift <= 8'h00;
    end else if (bitcnt == 5'h08 && !wr_op) begin
      rd_phase <= 1'b1;
      rd_shift <= rdata_in;
    end else if (bitcnt == 5'h00) begin
      rd_phase <= 1'b0;
    end else if (rd_phase) begin
      rd_shift <= {rd_shift[6:0], 1'b0};
    end
  end

  assign sdio_out = rd_shift[7];
  assign sdio_oe_out = rd_phase;
endmodule

//--- oms_regs.sv
// oms_regs: register bank of the optical motion sensor behind the two-wire serial port
// assumes: frame statistics and motion deltas arrive from the imaging pipeline on ref_clk_in;
// the controller waits long enough between address and data for the read to cross domains
// Function
// R01 - registers reachable only through the two-wire serial port
// R02 - configuration bit 6 set powers down analog circuitry
// R03 - bit 0 clear: sleep after one quiet second; set: stay awake
// R04 - status bit 0 shows awake as 1, asleep as 0
// R05 - status bits 7:5 give fixed part code, bits 4:1 reserved
// R06 - Y motion accumulates displacement; read clears it (a read at DY2 returns the count without clearing it)
// R07 - X motion accumulates two's complement displacement; read clears it (a read at DX2 returns the count without clearing it)
// R08 - motion magnitude scaled by selected resolution setting
// R09 - controller reads Y motion before X motion
// R10 - surface quality reports upper eight of nine bits, never above 128
// R11 - brightest pixel in bits 6:0, bit 7 always zero
// R12 - writing 0x80 to configuration soft resets; device clears reset bit
// R13 - unmapped write ignored, unmapped read returns zero
// R14 - reserved configuration and status bits read zero
module oms_regs
  import oms_pkg::*;
#(
  parameter logic [2:0] PART_CODE = 3'h5, // arbitrary value
  parameter logic [7:0] PROD_CODE_A = 8'h5a, // arbitrary value
  parameter logic [7:0] PROD_CODE_B = 8'h5b, // arbitrary value
  parameter int SLEEP_CYC = OMS_SLEEP_CYC,
  parameter int RES_SHIFT_W = 3
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic sdio_in,
  input wire logic [7:0] dy_step_in,
  input wire logic [7:0] dx_step_in,
  input wire logic step_valid_in,
  input wire oms_frame_t frame_in,
  input wire logic [7:0] pixel_in,
  output logic sdio_out,
  output logic sdio_oe_out,
  output logic analog_shutdown_out,
  output logic awake_out,
  output logic soft_reset_out
);
  // ****************************************
  // serial engine
  // ****************************************
  // sdio is sampled by the clock that launches it, so it needs no synchroniser
  logic [7:0] rdata;
  oms_req_t req;
  logic req_tgl;
  logic ser_sdio;
  logic ser_oe;

  oms_serial u_ser (
    .sclk_in(sclk_in),
    .rst_in(rst_in),
    .sdio_in(sdio_in),
    .rdata_in(rdata),
    .sdio_out(ser_sdio),
    .sdio_oe_out(ser_oe),
    .req_out(req),
    .req_tgl_out(req_tgl)
  );

  // engine flops drive the pin directly; another stage would slip read data by one bit
  assign sdio_out = ser_sdio;
  assign sdio_oe_out = ser_oe;

  // ****************************************
  // request crossing into ref_clk_in
  // ****************************************
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;
  logic req_fire;
  oms_req_t req_c;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      tgl_s1 <= req_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  assign req_fire = tgl_s2 ^ tgl_s3;
  assign req_c = req; // stable while toggle crosses

  // ****************************************
  // configuration
  // ****************************************
  logic [7:0] cfg1;
  logic [7:0] cfg2;
  logic [7:0] cfg3;
  logic [7:0] opm2;
  logic [7:0] pctl;
  logic [7:0] grab;
  logic wr_hit;
  logic rd_hit;
  logic soft_rst;

  assign wr_hit = req_fire && req_c.wr; // R01
  assign rd_hit = req_fire && !req_c.wr;
  assign soft_rst = wr_hit && (req_c.addr == OMS_ADDR_CFG1 || req_c.addr == OMS_ADDR_CFG3) &&
                    req_c.data[OMS_CFG_RESET_BIT];

  // soft reset keeps written bits 6 and 0 only; reset bit self-clears by never being stored
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg1 <= OMS_RST_CFG;
      soft_reset_out <= 1'b0;
    end else begin
      soft_reset_out <= soft_rst; // R12
      if (wr_hit && (req_c.addr == OMS_ADDR_CFG1 || req_c.addr == OMS_ADDR_CFG3)) begin
        cfg1 <= req_c.data & OMS_CFG_KEEP_MASK; // R12 R14
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg2 <= OMS_RST_ZERO;
      opm2 <= OMS_RST_OPM;
      pctl <= OMS_RST_PCTL;
      grab <= OMS_RST_ZERO;
    end else if (soft_rst) begin
      cfg2 <= OMS_RST_ZERO;
      opm2 <= OMS_RST_OPM;
      pctl <= OMS_RST_PCTL;
      grab <= OMS_RST_ZERO;
    end else if (wr_hit) begin
      // unmapped addresses fall through with no effect
      unique case (req_c.addr)
        OMS_ADDR_CFG2: cfg2 <= req_c.data;
        OMS_ADDR_OPM2: opm2 <= req_c.data;
        OMS_ADDR_PCTL: pctl <= req_c.data;
        OMS_ADDR_GRAB: grab <= req_c.data;
        default: ; // R13
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      analog_shutdown_out <= 1'b0;
    end else begin
      analog_shutdown_out <= cfg1[OMS_CFG_SHUTDOWN_BIT]; // R02
    end
  end
  assign cfg3 = cfg1;

  // ****************************************
  // sleep timer
  // ****************************************
  logic [31:0] idle_cnt;
  logic moved;

  assign moved = step_valid_in && (dy_step_in != 8'h00 || dx_step_in != 8'h00);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      idle_cnt <= 32'h0;
      awake_out <= 1'b1;
    end else if (soft_rst || moved || cfg1[OMS_CFG_WAKE_BIT]) begin
      idle_cnt <= 32'h0; // R03
      awake_out <= 1'b1;
    end else if (idle_cnt >= 32'(SLEEP_CYC - 1)) begin
      awake_out <= 1'b0; // R03 R04
    end else begin
      idle_cnt <= idle_cnt + 32'h1;
    end
  end

  // ****************************************
  // motion accumulators
  // ****************************************
  logic [7:0] dy;
  logic [7:0] dx;
  logic [7:0] dy_scaled;
  logic [7:0] dx_scaled;
  logic rd_dy;
  logic rd_dx;

  function automatic logic [7:0] oms_scale(input logic [7:0] v, input logic [2:0] res);
    // resolution field steps the count by a signed shift right from full scale
    oms_scale = 8'($signed(v) >>> (3'h7 - res));
  endfunction

  assign dy_scaled = oms_scale(dy_step_in, pctl[RES_SHIFT_W-1:0]); // R08
  assign dx_scaled = oms_scale(dx_step_in, pctl[RES_SHIFT_W-1:0]); // R08
  assign rd_dy = rd_hit && (req_c.addr == OMS_ADDR_DY1 || req_c.addr == OMS_ADDR_DY3);
  assign rd_dx = rd_hit && (req_c.addr == OMS_ADDR_DX1 || req_c.addr == OMS_ADDR_DX3);

  // a step landing in the clearing cycle becomes the new count, so no motion is lost
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dy <= OMS_RST_ZERO;
    end else if (soft_rst) begin
      dy <= OMS_RST_ZERO;
    end else if (rd_dy) begin
      dy <= step_valid_in ? dy_scaled : 8'h00; // R06
    end else if (step_valid_in) begin
      dy <= dy + dy_scaled; // R06
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dx <= OMS_RST_ZERO;
    end else if (soft_rst) begin
      dx <= OMS_RST_ZERO;
    end else if (rd_dx) begin
      dx <= step_valid_in ? dx_scaled : 8'h00; // R07
    end else if (step_valid_in) begin
      dx <= dx + dx_scaled; // R07
    end
  end

  // ****************************************
  // frame statistics
  // ****************************************
  logic [7:0] surface_feature_count;
  logic [7:0] maxp;
  logic [7:0] minp;
  logic [7:0] psum;
  logic [15:0] expo;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      surface_feature_count <= OMS_RST_ZERO;
      maxp <= OMS_RST_ZERO;
      minp <= OMS_RST_MINP;
      psum <= OMS_RST_ZERO;
      expo <= {OMS_RST_SHU, OMS_RST_ZERO};
    end else if (step_valid_in) begin
      // clamp protects the ceiling even if the counter overshoots
      surface_feature_count <= (frame_in.features[8:1] > OMS_SQ_MAX) ? OMS_SQ_MAX : frame_in.features[8:1]; // R10
      maxp <= {1'b0, frame_in.brightest}; // R11
      minp <= {2'b00, frame_in.darkest};
      psum <= frame_in.pix_total;
      expo <= frame_in.exposure;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  logic [7:0] status;
  logic [7:0] next_rdata;

  assign status = {PART_CODE, 4'h0, awake_out}; // R04 R05 R14

  always_comb begin
    next_rdata = 8'h00; // R13
    unique case (req_c.addr)
      OMS_ADDR_CFG1, OMS_ADDR_CFG3: next_rdata = cfg3;
      OMS_ADDR_STAT1, OMS_ADDR_STAT3: next_rdata = status;
      OMS_ADDR_DY1, OMS_ADDR_DY3: next_rdata = dy;
      OMS_ADDR_DX1, OMS_ADDR_DX3: next_rdata = dx;
      OMS_ADDR_DY2: next_rdata = dy;
      OMS_ADDR_DX2: next_rdata = dx;
      OMS_ADDR_SQ1, OMS_ADDR_SQ2, OMS_ADDR_SQ3: next_rdata = surface_feature_count;
      OMS_ADDR_MAXP1, OMS_ADDR_MAXP3: next_rdata = maxp;
      OMS_ADDR_MINP1, OMS_ADDR_MINP3: next_rdata = minp;
      OMS_ADDR_PSUM1, OMS_ADDR_PSUM3: next_rdata = psum;
      OMS_ADDR_PDAT1, OMS_ADDR_PDAT3: next_rdata = pixel_in;
      OMS_ADDR_SHU1, OMS_ADDR_SHU3: next_rdata = expo[15:8];
      OMS_ADDR_SHL1, OMS_ADDR_SHL3: next_rdata = expo[7:0];
      OMS_ADDR_GRAB: next_rdata = grab;
      OMS_ADDR_PIDA: next_rdata = PROD_CODE_A;
      OMS_ADDR_PIDB: next_rdata = PROD_CODE_B;
      OMS_ADDR_MOT2: next_rdata = {(dy != 8'h00 || dx != 8'h00), 7'h00};
      OMS_ADDR_OPM2: next_rdata = opm2;
      OMS_ADDR_CFG2: next_rdata = cfg2;
      OMS_ADDR_PCTL: next_rdata = pctl;
      default: next_rdata = 8'h00;
    endcase
  end

  // captured before the clear; controller leaves the crossing time before data clocks
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata <= 8'h00;
    end else if (rd_hit) begin
      rdata <= next_rdata;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_surface_feature_count_cap: assert property (@(posedge ref_clk_in) disable iff (rst_in) surface_feature_count <= OMS_SQ_MAX) // R10
    else $error("surface quality above ceiling");
  chk_bright_msb: assert property (@(posedge ref_clk_in) disable iff (rst_in) !maxp[7]) // R11
    else $error("brightest pixel bit 7 set");
  chk_dy_clear: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R06
    rd_dy && !step_valid_in && !soft_rst |=> dy == 8'h00)
    else $error("y motion not cleared by read");
  chk_dx_clear: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R07
    rd_dx && !step_valid_in && !soft_rst |=> dx == 8'h00)
    else $error("x motion not cleared by read");
  chk_shutdown_follow: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R02
    wr_hit && req_c.addr == OMS_ADDR_CFG1 |=> ##1 analog_shutdown_out == $past(req_c.data[6], 2))
    else $error("shutdown does not follow config");
  chk_reset_self: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R12
    soft_rst |=> soft_reset_out && !cfg1[OMS_CFG_RESET_BIT] ##1 !soft_reset_out || soft_rst)
    else $error("soft reset bit not self cleared");
  chk_status_bits: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R05
    rd_hit && req_c.addr == OMS_ADDR_STAT1 |=> rdata[4:1] == 4'h0 && rdata[7:5] == PART_CODE)
    else $error("status layout wrong");
  chk_forced_awake: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R03
    cfg1[OMS_CFG_WAKE_BIT] |=> awake_out)
    else $error("forced awake slept");
  chk_unmapped_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R13
    rd_hit && req_c.addr == 7'h77 |=> rdata == 8'h00)
    else $error("unmapped read nonzero");
  chk_soft_clear: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R12
    soft_rst |=> dy == 8'h00 && dx == 8'h00 && opm2 == OMS_RST_OPM)
    else $error("soft reset left state behind");
  chk_awake_move: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R03
    moved |=> awake_out)
    else $error("motion did not wake sensor");
  chk_sleep_idle: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R03
    !soft_rst && !moved && !cfg1[OMS_CFG_WAKE_BIT] && idle_cnt >= 32'(SLEEP_CYC - 1) |=> !awake_out)
    else $error("sensor stayed awake after idle time");
  chk_read_capture: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R06
    rd_dy |=> rdata == $past(dy))
    else $error("y motion read lost count");
  chk_dy_accum: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R06
    step_valid_in && !rd_dy && !soft_rst |=> dy == 8'($past(dy) + $past(dy_scaled)))
    else $error("y motion not accumulated");
  chk_dx_accum: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R07
    step_valid_in && !rd_dx && !soft_rst |=> dx == 8'($past(dx) + $past(dx_scaled)))
    else $error("x motion not accumulated");
  chk_feature_upper: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R10
    step_valid_in && frame_in.features[8:1] <= OMS_SQ_MAX |=> surface_feature_count == $past(frame_in.features[8:1]))
    else $error("surface quality not upper bits");
endmodule

//--- oms_host.sv
// oms_host: behavioural microcontroller driving the two-wire serial port
// assumes: the testbench resolves the shared data wire and feeds it back on sdio_in
module oms_host (
  input wire logic sdio_in,
  output logic sclk_out,
  output logic sdio_out,
  output logic sdio_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // idle: clock parked high, data released
  // ****************************************
  initial begin
    sclk_out = 1'b1;
    sdio_out = 1'b1;
    sdio_oe_out = 1'b0;
  end
  // ****************************************
  // one transaction, msb first, 15 ns clock only inside the frame
  // ****************************************
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {wr, addr, wdata};
    rdata = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      if (i == 7) begin
        // let go before the turnaround edge so the device can drive
        if (!wr) sdio_oe_out = 1'b0;
        #300;
      end
      sclk_out = 1'b0;
      if (wr || i > 7) begin
        sdio_out = frame[i];
        sdio_oe_out = 1'b1;
      end
      #7.5;
      sclk_out = 1'b1;
      if (!wr && i < 8) rdata[i] = sdio_in;
      #7.5;
    end
    sdio_oe_out = 1'b0;
    // long gap also covers the write crossing into the core clock
    #400;
  endtask
  // y is always fetched before x in a motion readout
  task automatic read_motion(output logic [7:0] dy, output logic [7:0] dx);
    xfer(1'b0, 7'h02, 8'h00, dy);
    xfer(1'b0, 7'h03, 8'h00, dx);
  endtask
endmodule

//--- testbench.sv
// testbench: register bank checks through the two-wire serial port
// assumes: oms_host plays the controller; frame inputs are driven on the core clock
module testbench import oms_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_in, rst_in, step_valid_in, sclk, host_bit, host_en, sdio_wire;
  logic float_bit = 1'b1;
  logic sdio_out, sdio_oe_out, analog_shutdown_out, awake_out, soft_reset_out;
  logic [7:0] dy_step_in, dx_step_in, pixel_in, rd_y, rd_x;
  oms_frame_t frame_in;
  int miscompares = 0;
  int tests_run = 0;
  int reset_pulses = 0;
  logic [6:0] tbl_addr [13] = '{7'h00, 7'h02, 7'h03, 7'h06, 7'h09, 7'h0a, 7'h14, 7'h15,
                                7'h1a, 7'h33, 7'h46, 7'h49, 7'h77};
  logic [7:0] tbl_exp [13] = '{8'h00, 8'h00, 8'h00, 8'h3f, 8'h01, 8'h00, 8'h3c, 8'h3d,
                               8'h04, 8'h07, 8'h3f, 8'h01, 8'h00};
  // released wire shows the inverse of whoever drove it last
  assign sdio_wire = host_en ? host_bit : (sdio_oe_out ? sdio_out : float_bit);
  oms_regs #(.PART_CODE(3'h6), .PROD_CODE_A(8'h3c), .PROD_CODE_B(8'h3d), .SLEEP_CYC(50),
             .RES_SHIFT_W(3)) u_oms_regs (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .sclk_in(sclk), .sdio_in(sdio_wire),
    .dy_step_in(dy_step_in), .dx_step_in(dx_step_in), .step_valid_in(step_valid_in),
    .frame_in(frame_in), .pixel_in(pixel_in), .sdio_out(sdio_out),
    .sdio_oe_out(sdio_oe_out), .analog_shutdown_out(analog_shutdown_out),
    .awake_out(awake_out), .soft_reset_out(soft_reset_out));
  oms_host u_oms_host (.sdio_in(sdio_wire), .sclk_out(sclk), .sdio_out(host_bit),
                       .sdio_oe_out(host_en));
  // ****************************************
  // clock, wire filler, pulse counter
  // ****************************************
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  always @(host_en, host_bit, sdio_oe_out, sdio_out) begin
    if (host_en) float_bit = ~host_bit;
    else if (sdio_oe_out) float_bit = ~sdio_out;
  end
  always @(posedge ref_clk_in) begin
    if (soft_reset_out === 1'b1) reset_pulses <= reset_pulses + 1;
  end
  // ****************************************
  // compare and access tasks
  // ****************************************
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_oms_host.xfer(1'b0, a, 8'h00, d);
    check8(what, exp, d);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    u_oms_host.xfer(1'b1, a, d, unused);
  endtask
  task automatic step(input logic [7:0] dy, input logic [7:0] dx, input oms_frame_t fr);
    @(posedge ref_clk_in);
    dy_step_in <= dy;
    dx_step_in <= dx;
    frame_in <= fr;
    step_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    step_valid_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a full run needs well under 100 us
  initial begin
    #300000;
    miscompares++;
    close_out();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    rst_in = 1'b1;
    step_valid_in = 1'b0;
    dy_step_in = 8'h00;
    dx_step_in = 8'h00;
    pixel_in = 8'h2a;
    frame_in = '0;
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    rd_chk("status", OMS_ADDR_STAT1, 8'hc1);
    for (int i = 0; i < 13; i++) rd_chk("reset value", tbl_addr[i], tbl_exp[i]);
    @(negedge ref_clk_in);
    check1("awake", 1'b0, awake_out);
    rd_chk("status", OMS_ADDR_STAT1, 8'hc0);
    wr(7'h77, 8'hff);
    rd_chk("unmapped", 7'h77, 8'h00);
    rd_chk("config", OMS_ADDR_CFG1, 8'h00);
    step(8'h03, 8'hfb, '0);
    step(8'h04, 8'hfd, '0);
    check1("awake", 1'b1, awake_out);
    u_oms_host.read_motion(rd_y, rd_x);
    check8("motion y", 8'h07, rd_y);
    check8("motion x", 8'hf8, rd_x);
    u_oms_host.read_motion(rd_y, rd_x);
    check8("motion y", 8'h00, rd_y);
    check8("motion x", 8'h00, rd_x);
    wr(OMS_ADDR_PCTL, 8'h05);
    step(8'hf0, 8'h0c, '0);
    u_oms_host.read_motion(rd_y, rd_x);
    check8("motion y", 8'hfc, rd_y);
    check8("motion x", 8'h03, rd_x);
    wr(OMS_ADDR_PCTL, 8'h07);
    wr(OMS_ADDR_CFG1, 8'h01);
    repeat (150) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    check1("awake", 1'b1, awake_out);
    rd_chk("status", OMS_ADDR_STAT3, 8'hc1);
    wr(OMS_ADDR_CFG1, 8'h41);
    rd_chk("config", OMS_ADDR_CFG1, 8'h41);
    rd_chk("config", OMS_ADDR_CFG3, 8'h41);
    check1("shutdown", 1'b1, analog_shutdown_out);
    check8("reset pulses", 8'h00, 8'(reset_pulses));
    wr(OMS_ADDR_OPM2, 8'h05);
    rd_chk("mode", OMS_ADDR_OPM2, 8'h05);
    step(8'h02, 8'h02, '0);
    wr(OMS_ADDR_CFG1, 8'hc1);
    check8("reset pulses", 8'h01, 8'(reset_pulses));
    rd_chk("config", OMS_ADDR_CFG1, 8'h41);
    rd_chk("mode", OMS_ADDR_OPM2, 8'h04);
    rd_chk("motion y", OMS_ADDR_DY1, 8'h00);
    wr(OMS_ADDR_CFG1, 8'h00);
    @(negedge ref_clk_in);
    check1("shutdown", 1'b0, analog_shutdown_out);
    // top feature count must clamp at the documented ceiling
    step(8'h00, 8'h00, {9'h1ff, 7'h7f, 6'h00, 8'h00, 16'h0000});
    rd_chk("surface", OMS_ADDR_SQ1, 8'h80);
    rd_chk("brightest", OMS_ADDR_MAXP1, 8'h7f);
    step(8'h00, 8'h00, {9'h0f5, 7'h12, 6'h00, 8'h00, 16'h0000});
    rd_chk("surface", OMS_ADDR_SQ1, 8'h7a);
    rd_chk("brightest", OMS_ADDR_MAXP1, 8'h12);
    close_out();
  end
endmodule
